// ### tb/etws_chk.sv
// concurrent checks on the two-wire bus between master and memory front end
`include "etws_defs.svh"
`default_nettype none
module etws_chk
  #(
  parameter logic [3:0] TYPE_CODE = 4'h6
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // two-wire bus
  input  wire logic scl,
  input  wire logic m_sda_oe,
  input  wire logic d_sda_oe,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HOLD_CYC = `ETWS_HOLD_CYC;

  // ----------------------------------------------------------------------------
  // bus tracking
  // ----------------------------------------------------------------------------
  logic       scl_ff;
  logic       sda_ff;
  logic       rd_ff;
  logic       byte_ff;
  logic       ign_ff;
  logic       nack_ff;
  logic       idle_ff;
  logic [3:0] bitn_ff;
  logic [7:0] shreg_ff;
  logic [7:0] fall_cnt_ff;
  logic       rise_ev;
  logic       start_ev;
  logic       stop_ev;

  // raw line edges: the design filters, so its view lags ours
  assign rise_ev  = scl & ~scl_ff;
  assign start_ev = scl & scl_ff & sda_ff & ~sda;
  assign stop_ev  = scl & scl_ff & ~sda_ff & sda;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
    end else begin
      scl_ff <= scl;
      sda_ff <= sda;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || start_ev || stop_ev) begin
      bitn_ff <= 4'h0;
      byte_ff <= 1'b0;
    end else if (rise_ev) begin
      bitn_ff <= (bitn_ff == 4'h8) ? 4'h0 : bitn_ff + 4'h1;
      byte_ff <= byte_ff | (bitn_ff == 4'h8);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shreg_ff <= 8'h00;
      rd_ff    <= 1'b0;
    end else if (rise_ev) begin
      shreg_ff <= {shreg_ff[6:0], sda};
      rd_ff    <= (!byte_ff && bitn_ff == 4'h7) ? sda : rd_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || stop_ev) begin
      idle_ff <= 1'b1;
      ign_ff  <= 1'b0;
      nack_ff <= 1'b0;
    end else if (start_ev) begin
      idle_ff <= 1'b0;
      ign_ff  <= 1'b0;
      nack_ff <= 1'b0;
    end else if (rise_ev && bitn_ff == 4'h8) begin
      ign_ff  <= ign_ff | (!byte_ff && shreg_ff[7:4] != TYPE_CODE);
      nack_ff <= nack_ff | (byte_ff && rd_ff && sda);
    end
  end

  // saturates so a long idle never wraps into a false short gap
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fall_cnt_ff <= 8'hFF;
    end else if (scl_ff && !scl) begin
      fall_cnt_ff <= 8'h00;
    end else if (fall_cnt_ff != 8'hFF) begin
      fall_cnt_ff <= fall_cnt_ff + 8'h01;
    end
  end

  // ----------------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_ack_rise;
    $rose(scl) && bitn_ff == 4'h8 && d_sda_oe;
  endsequence
  sequence s_ctl_end;
    $rose(scl) && !byte_ff && bitn_ff == 4'h8;
  endsequence

  property p_dev_high;  scl && $past(scl) |-> $stable(d_sda_oe); endproperty
  // a Stop or repeated Start comes one clock rise after a whole byte
  property p_mst_high;
    scl && $past(scl) && $changed(m_sda_oe) |-> bitn_ff == 4'h0 || (bitn_ff == 4'h1 && byte_ff);
  endproperty
  property p_out_delay; $changed(d_sda_oe) |-> fall_cnt_ff >= HOLD_CYC; endproperty
  property p_ack_slot;  $rose(scl) && d_sda_oe && (!byte_ff || !rd_ff) |-> bitn_ff == 4'h8; endproperty
  property p_ack_hold;  s_ack_rise |-> (d_sda_oe && !sda) [*8]; endproperty
  property p_mismatch;  s_ctl_end ##0 (shreg_ff[7:4] != TYPE_CODE) |-> !d_sda_oe; endproperty
  property p_ign_quiet; ign_ff |-> !d_sda_oe; endproperty
  property p_nack_quiet; nack_ff |-> !d_sda_oe; endproperty
  property p_idle_quiet; idle_ff |-> !d_sda_oe; endproperty

  a_dev_high:   assert property (p_dev_high)   else $error("device data changed while clock high");
  a_mst_high:   assert property (p_mst_high)   else $error("master data changed inside a byte");
  a_out_delay:  assert property (p_out_delay)  else $error("device output changed too soon after fall");
  a_ack_slot:   assert property (p_ack_slot)   else $error("device drove outside the ninth pulse");
  a_ack_hold:   assert property (p_ack_hold)   else $error("acknowledge not held low");
  a_mismatch:   assert property (p_mismatch)   else $error("acknowledge on foreign type code");
  a_ign_quiet:  assert property (p_ign_quiet)  else $error("device drove while ignoring bus");
  a_nack_quiet: assert property (p_nack_quiet) else $error("device drove after master nack");
  a_idle_quiet: assert property (p_idle_quiet) else $error("device drove after stop");

  c_ack:  cover property (s_ack_rise);
  c_nack: cover property ($rose(nack_ff));
endmodule // etws_chk
`default_nettype wire

// ### tb/etws_tb.sv
// self-checking bench: master and memory front end joined over the two-wire bus
`include "etws_defs.svh"
`default_nettype none
`define ETWS_CHK(got_v, exp_v) \
  begin \
    tests_run++; \
    if ((got_v) !== (exp_v)) begin \
      error_cnt++; \
      $display("CHECK FAILED at %0t: value %0h, expected %0h", $time, (got_v), (exp_v)); \
    end \
  end
module etws_tb;
  import etws_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] TYPE_CODE = 4'h9; // arbitrary value
  localparam int         TWC_CYC   = 3000;
  localparam int         LIMIT     = 95000;

  logic       clk;
  logic       sys_rst;
  logic       cmd_valid;
  logic       cmd_ready;
  logic       cmd_nack;
  logic       rsp_valid;
  logic       rsp_ack;
  logic       mem_wr_en;
  logic       busy;
  logic       ackv;
  logic [2:0] blk;
  etws_cmd_t  cmd_kind;
  etws_byte_t cmd_data;
  etws_byte_t rsp_data;
  etws_byte_t mem_rd_data;
  etws_byte_t mem_wr_data;
  etws_byte_t got;
  etws_addr_t mem_addr;
  etws_addr_t mem_wr_addr;
  etws_addr_t base;
  etws_byte_t mem     [1024];
  etws_byte_t exp_mem [1024];
  int         error_cnt = 0;
  int         tests_run = 0;
  int         seed = 4989;
  int         cyc = 0;

  // ----------------------------------------------------------------------------
  // design, bus and memory array
  // ----------------------------------------------------------------------------
  etws_bus_if bus ();

  etws_master etws_master_inst (.clk(clk), .sys_rst(sys_rst), .bus(bus), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_data(cmd_data), .cmd_nack(cmd_nack),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack));

  etws_device #(.TYPE_CODE(TYPE_CODE), .TWC_CYC(TWC_CYC)) etws_device_inst (.clk(clk), .sys_rst(sys_rst),
    .bus(bus), .mem_addr(mem_addr), .mem_rd_data(mem_rd_data), .mem_wr_en(mem_wr_en),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .busy(busy));

  etws_chk #(.TYPE_CODE(TYPE_CODE)) etws_chk_inst (.clk(clk), .sys_rst(sys_rst), .scl(bus.scl),
    .m_sda_oe(bus.m_sda_oe), .d_sda_oe(bus.d_sda_oe), .sda(bus.sda));

  assign mem_rd_data = mem[mem_addr];

  always @(posedge clk) begin
    if (mem_wr_en === 1'b1) begin
      mem[mem_wr_addr] <= mem_wr_data;
    end
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  function automatic etws_byte_t ctl(input logic [3:0] ty, input logic [2:0] b, input logic rw);
    return {ty, b, rw};
  endfunction

  // page buffer index wraps inside the 16-byte page
  function automatic etws_addr_t page_slot(input etws_addr_t a, input int i);
    return {a[9:4], a[3:0] + i[3:0]};
  endfunction

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // request held from one falling edge until the rising edge that takes it
  task automatic send(input etws_cmd_t kind, input etws_byte_t data, input logic nack);
    int n;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_kind  = kind;
    cmd_data  = data;
    cmd_nack  = nack;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    n = 0;
    while (((kind inside {CMD_WRITE, CMD_READ}) ? rsp_valid : cmd_ready) !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    got  = rsp_data;
    ackv = rsp_ack;
  endtask

  task automatic wr_byte(input etws_byte_t d, input logic exp_ack);
    send(CMD_WRITE, d, 1'b0);
    `ETWS_CHK(ackv, exp_ack)
    `ETWS_CHK(got, d)
  endtask

  task automatic wait_busy_low(output int n);
    n = 0;
    while (busy !== 1'b0 && n < 5000) begin
      @(negedge clk);
      n++;
    end
  endtask

  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  initial begin
    int         n;
    etws_byte_t d;
    logic [3:0] bad;
    int         t0;
    sys_rst   = 1'b1;
    cmd_valid = 1'b0;
    cmd_kind  = CMD_START;
    cmd_data  = 8'h00;
    cmd_nack  = 1'b0;
    for (int i = 0; i < 1024; i++) begin
      mem[i]     = 8'($random(seed));
      exp_mem[i] = mem[i];
    end
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    `ETWS_CHK({bus.scl, bus.sda, busy}, 3'h6)

    // page write of 17 bytes from slot E: first slot overwritten by the last byte
    blk  = 3'($random(seed));
    base = {blk[1:0], 4'($random(seed)), 4'hE};
    send(CMD_START, 8'h00, 1'b0);
    wr_byte(ctl(TYPE_CODE, blk, 1'b0), 1'b1);
    wr_byte(base[7:0], 1'b1);
    for (int i = 0; i < 17; i++) begin
      d = 8'($random(seed));
      exp_mem[page_slot(base, i)] = d;
      wr_byte(d, 1'b1);
    end
    send(CMD_STOP, 8'h00, 1'b0);
    `ETWS_CHK(busy, 1'b1)
    t0 = cyc;

    // polling while the write cycle runs: no acknowledge
    send(CMD_START, 8'h00, 1'b0);
    wr_byte(ctl(TYPE_CODE, blk, 1'b0), 1'b0);
    send(CMD_STOP, 8'h00, 1'b0);
    wait_busy_low(n);
    `ETWS_CHK((cyc - t0 <= TWC_CYC) && n < 5000, 1'b1)
    for (int i = 0; i < 16; i++) begin
      `ETWS_CHK(mem[page_slot(base, i)], exp_mem[page_slot(base, i)])
    end
    send(CMD_START, 8'h00, 1'b0);
    wr_byte(ctl(TYPE_CODE, blk, 1'b0), 1'b1);
    send(CMD_STOP, 8'h00, 1'b0);

    // foreign type code: refused, later bytes ignored
    bad = TYPE_CODE ^ (4'($random(seed)) | 4'h1);
    send(CMD_START, 8'h00, 1'b0);
    wr_byte(ctl(bad, blk, 1'($random(seed))), 1'b0);
    wr_byte(8'($random(seed)), 1'b0);
    send(CMD_STOP, 8'h00, 1'b0);

    // random read across the page end, top select bit flipped
    send(CMD_START, 8'h00, 1'b0);
    wr_byte(ctl(TYPE_CODE, blk, 1'b0), 1'b1);
    wr_byte(base[7:0], 1'b1);
    send(CMD_START, 8'h00, 1'b0);
    wr_byte(ctl(TYPE_CODE, {~blk[2], blk[1:0]}, 1'b1), 1'b1);
    for (int i = 0; i < 3; i++) begin
      send(CMD_READ, 8'h00, i == 2);
      `ETWS_CHK(got, exp_mem[10'(base + i)])
      `ETWS_CHK(ackv, i != 2)
    end
    send(CMD_STOP, 8'h00, 1'b0);
    `ETWS_CHK({bus.scl, bus.sda, busy}, 3'h6)
    report_and_stop();
  end
endmodule // etws_tb
`default_nettype wire

// ### verilog/etws_bus_if.sv
// the two-wire bus between master and memory front end
`default_nettype none
interface etws_bus_if;
  logic scl;
  logic m_sda_oe;
  logic d_sda_oe;
  logic sda;

  // open-drain wired-and with pull-up
  assign sda = ~(m_sda_oe | d_sda_oe);

  modport master (output scl, output m_sda_oe, input sda);
  modport device (input scl, input sda, output d_sda_oe);
endinterface
`default_nettype wire

// ### verilog/etws_defs.svh
// timing and field constants for the two-wire serial memory front end
`ifndef ETWS_DEFS_SVH
`define ETWS_DEFS_SVH

// ----------------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------------
`define ETWS_CLK_MHZ       100
`define ETWS_GLITCH_NS     50
`define ETWS_GLITCH_CYC    ((`ETWS_GLITCH_NS * `ETWS_CLK_MHZ + 999) / 1000)
`define ETWS_HOLD_NS       300
`define ETWS_HOLD_CYC      ((`ETWS_HOLD_NS * `ETWS_CLK_MHZ + 999) / 1000)
`define ETWS_TWC_MS        5
`define ETWS_TWC_CYC       (`ETWS_TWC_MS * `ETWS_CLK_MHZ * 1000)
`define ETWS_QUARTER_NS    650
`define ETWS_QUARTER_CYC   ((`ETWS_QUARTER_NS * `ETWS_CLK_MHZ + 999) / 1000)

// ----------------------------------------------------------------------------
// byte framing and control byte fields
// ----------------------------------------------------------------------------
`define ETWS_BITS_PER_BYTE 8
`define ETWS_PAGE_BYTES    16
`define ETWS_CTL_TYPE_HI   7
`define ETWS_CTL_TYPE_LO   4
`define ETWS_CTL_BLK_TOP   3
`define ETWS_CTL_BLK_MID   2
`define ETWS_CTL_BLK_LOW   1
`define ETWS_CTL_RW        0

`endif

// ### verilog/etws_device.sv
// memory-side slave front end of the two-wire link
`include "etws_defs.svh"
`default_nettype none

// Behaviour
// - SDA falling, SCL high: Start, restart byte
// - SDA rising, SCL high: Stop, end operation
// - master opens with Start, closes with Stop
// - master starts only on idle bus
// - SDA changes only while SCL low
// - one SCL pulse per bit, sampled high
// - receiver acknowledges on ninth clock pulse
// - acknowledge holds SDA low whole high phase
// - no acknowledge during programming cycle
// - master nack ends read, device releases SDA
// - acknowledge control byte only on type match
// - low two block-select bits form upper address bits
// - control byte lsb: 1 read, 0 write
// - keep last sixteen bytes, oldest overwritten
// - write cycle at most 5 ms
// - output change waits hold delay after fall
// - filter glitches up to spike width
// - master makes clock, Start and Stop
// - write cycle starts at closing Stop
module etws_device
  #(
  parameter logic [3:0]  TYPE_CODE = 4'h6,            // arbitrary value
  parameter int unsigned TWC_CYC   = `ETWS_TWC_CYC
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               sys_rst,
  // two-wire bus
  etws_bus_if.device              bus,
  // memory array side
  output logic [9:0]              mem_addr,
  input  wire etws_pkg::etws_byte_t mem_rd_data,
  output logic                    mem_wr_en,
  output etws_pkg::etws_addr_t    mem_wr_addr,
  output etws_pkg::etws_byte_t    mem_wr_data,
  output logic                    busy
);
  import etws_pkg::*;

  localparam int         PAGE = `ETWS_PAGE_BYTES;
  localparam logic [2:0] GCYC = 3'(`ETWS_GLITCH_CYC);
  localparam logic [5:0] HOLD = 6'(`ETWS_HOLD_CYC);
  localparam int         TW   = $clog2(TWC_CYC + 1);

  // --------------------------------------------------------------------------
  // input synchroniser and spike filter (bit 0 clock, bit 1 data)
  // --------------------------------------------------------------------------
  logic [1:0] meta_ff;
  logic [1:0] sync_ff;
  logic [1:0] filt_ff;
  logic [1:0] prev_ff;
  logic [2:0] gcnt_ff [2];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_ff <= 2'h3;
      sync_ff <= 2'h3;
    end else begin
      meta_ff <= {bus.sda, bus.scl};
      sync_ff <= meta_ff;
    end
  end

  // a new level must persist longer than the spike width to be taken
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      filt_ff    <= 2'h3;
      prev_ff    <= 2'h3;
      gcnt_ff[0] <= 3'h0;
      gcnt_ff[1] <= 3'h0;
    end else begin
      prev_ff <= filt_ff;
      for (int i = 0; i < 2; i++) begin
        if (sync_ff[i] == filt_ff[i]) begin
          gcnt_ff[i] <= 3'h0;
        end else if (gcnt_ff[i] == GCYC) begin
          filt_ff[i] <= sync_ff[i];
          gcnt_ff[i] <= 3'h0;
        end else begin
          gcnt_ff[i] <= gcnt_ff[i] + 3'h1;
        end
      end
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic sda_f;

  assign sda_f     = filt_ff[1];
  assign scl_rise  = filt_ff[0] & ~prev_ff[0];
  assign scl_fall  = ~filt_ff[0] & prev_ff[0];
  assign start_det = filt_ff[0] & prev_ff[0] & prev_ff[1] & ~filt_ff[1];
  assign stop_det  = filt_ff[0] & prev_ff[0] & ~prev_ff[1] & filt_ff[1];

  // --------------------------------------------------------------------------
  // bit counter and receive shifter
  // --------------------------------------------------------------------------
  logic [3:0] bit_cnt_ff;
  logic [7:0] rx_ff;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bit_cnt_ff <= 4'h0;
      rx_ff      <= 8'h00;
    end else if (start_det) begin
      // the clock fall that closes the Start wraps this to zero
      bit_cnt_ff <= 4'hF;
    end else begin
      if (scl_rise && bit_cnt_ff < 4'h8) begin
        rx_ff <= {rx_ff[6:0], sda_f};
      end
      if (scl_fall) begin
        bit_cnt_ff <= (bit_cnt_ff == 4'h8) ? 4'h0 : bit_cnt_ff + 4'h1;
      end
    end
  end

  logic byte_end;
  logic ack_end;
  logic ack_smp;
  assign byte_end = scl_fall && bit_cnt_ff == 4'h7;
  assign ack_end  = scl_fall && bit_cnt_ff == 4'h8;
  assign ack_smp  = scl_rise && bit_cnt_ff == 4'h8;

  // --------------------------------------------------------------------------
  // transfer state, address pointer and page buffer
  // --------------------------------------------------------------------------
  etws_dev_state_t state_ff;
  logic            ack_ff;
  logic [9:0]      ptr_ff;
  logic [7:0]      buf_ff [PAGE];
  logic [15:0]     mask_ff;
  logic            twc_busy;
  logic            ctl_match;

  assign ctl_match = rx_ff[`ETWS_CTL_TYPE_HI:`ETWS_CTL_TYPE_LO] == TYPE_CODE;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= DS_IDLE;
      ack_ff   <= 1'b0;
      ptr_ff   <= 10'h000;
      mask_ff  <= 16'h0000;
    end else if (start_det) begin
      state_ff <= DS_CTRL;
      ack_ff   <= 1'b0;
    end else if (stop_det) begin
      state_ff <= DS_IDLE;
      ack_ff   <= 1'b0;
    end else if (byte_end) begin
      unique case (state_ff)
        DS_CTRL: begin
          if (ctl_match && !twc_busy) begin
            ack_ff      <= 1'b1;
            // top select bit is a don't care
            ptr_ff[9:8] <= {rx_ff[`ETWS_CTL_BLK_MID], rx_ff[`ETWS_CTL_BLK_LOW]};
            if (!rx_ff[`ETWS_CTL_RW]) begin
              mask_ff <= 16'h0000;
            end
          end else begin
            state_ff <= DS_IGNORE;
          end
        end
        DS_ADDR: begin
          ack_ff      <= 1'b1;
          ptr_ff[7:0] <= rx_ff;
        end
        DS_WDATA: begin
          // low nibble rolls over, so later bytes replace the oldest
          ack_ff              <= 1'b1;
          buf_ff[ptr_ff[3:0]]  <= rx_ff;
          mask_ff[ptr_ff[3:0]] <= 1'b1;
          ptr_ff[3:0]          <= ptr_ff[3:0] + 4'h1;
        end
        DS_IDLE, DS_RDATA, DS_IGNORE: begin
          ack_ff <= 1'b0;
        end
        default: begin
          state_ff <= DS_IGNORE;
          ack_ff   <= 1'b0;
        end
      endcase
    end else if (ack_end) begin
      ack_ff <= 1'b0;
      if (ack_ff && state_ff == DS_CTRL) begin
        state_ff <= rx_ff[`ETWS_CTL_RW] ? DS_RDATA : DS_ADDR;
      end else if (ack_ff && state_ff == DS_ADDR) begin
        state_ff <= DS_WDATA;
      end
    end else if (ack_smp && state_ff == DS_RDATA) begin
      ptr_ff <= ptr_ff + 10'h001;
      if (sda_f) begin
        state_ff <= DS_IGNORE;
      end
    end
  end

  // --------------------------------------------------------------------------
  // transmit shifter
  // --------------------------------------------------------------------------
  logic [7:0] tx_ff;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_ff <= 8'hFF;
    end else if (ack_end) begin
      tx_ff <= mem_rd_data;
    end else if (scl_fall && bit_cnt_ff < 4'h7) begin
      tx_ff <= {tx_ff[6:0], 1'b1};
    end
  end

  // --------------------------------------------------------------------------
  // delayed data output
  // --------------------------------------------------------------------------
  logic       drive_low;
  logic [5:0] dly_ff;
  logic       oe_ff;

  // released in the master's acknowledge slot of a read, and when ignoring
  assign drive_low = (bit_cnt_ff == 4'h8) ? ack_ff
                                          : (state_ff == DS_RDATA && !tx_ff[7]);

  // waiting out the clock's falling slope keeps a change from looking like Start or Stop
  always_ff @(posedge clk) begin
    if (sys_rst || start_det || stop_det) begin
      dly_ff <= 6'h00;
      oe_ff  <= 1'b0;
    end else if (scl_fall) begin
      dly_ff <= HOLD;
    end else if (dly_ff != 6'h00) begin
      dly_ff <= dly_ff - 6'h01;
      if (dly_ff == 6'h01) begin
        oe_ff <= drive_low;
      end
    end
  end

  assign bus.d_sda_oe = oe_ff;
  assign mem_addr     = ptr_ff;

  // --------------------------------------------------------------------------
  // self-timed write cycle
  // --------------------------------------------------------------------------
  logic          cmt_ff;
  logic [3:0]    cidx_ff;
  logic [TW-1:0] twc_ff;

  assign twc_busy = twc_ff != '0;
  assign busy     = twc_busy;

  // the page drains in sixteen cycles, well inside the timer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmt_ff  <= 1'b0;
      cidx_ff <= 4'h0;
      twc_ff  <= '0;
    end else if (stop_det && state_ff == DS_WDATA && mask_ff != 16'h0000) begin
      cmt_ff  <= 1'b1;
      cidx_ff <= 4'h0;
      twc_ff  <= TW'(TWC_CYC);
    end else begin
      if (cmt_ff) begin
        cidx_ff <= cidx_ff + 4'h1;
        cmt_ff  <= cidx_ff != 4'hF;
      end
      if (twc_busy) begin
        twc_ff <= twc_ff - 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mem_wr_en   <= 1'b0;
      mem_wr_addr <= 10'h000;
      mem_wr_data <= 8'h00;
    end else begin
      mem_wr_en   <= cmt_ff && mask_ff[cidx_ff];
      mem_wr_addr <= {ptr_ff[9:4], cidx_ff};
      mem_wr_data <= buf_ff[cidx_ff];
    end
  end
endmodule // etws_device
`default_nettype wire

// ### verilog/etws_master.sv
// bus-master end of the two-wire link, byte-level command port
`include "etws_defs.svh"
`default_nettype none
module etws_master
  #(
  parameter int unsigned QUARTER_CYC = `ETWS_QUARTER_CYC
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // two-wire bus
  etws_bus_if.master                bus,
  // command port
  input  wire logic                 cmd_valid,
  output logic                      cmd_ready,
  input  wire etws_pkg::etws_cmd_t  cmd_kind,
  input  wire etws_pkg::etws_byte_t cmd_data,
  input  wire logic                 cmd_nack,
  // response port
  output logic                      rsp_valid,
  output etws_pkg::etws_byte_t      rsp_data,
  output logic                      rsp_ack
);
  import etws_pkg::*;

  localparam int QW = $clog2(QUARTER_CYC + 1);

  // --------------------------------------------------------------------------
  // data line synchroniser and quarter-bit divider
  // --------------------------------------------------------------------------
  logic          meta_ff;
  logic          sda_s_ff;
  logic [QW-1:0] qcnt_ff;
  logic          tick;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_ff  <= 1'b1;
      sda_s_ff <= 1'b1;
    end else begin
      meta_ff  <= bus.sda;
      sda_s_ff <= meta_ff;
    end
  end

  assign tick = qcnt_ff == QW'(QUARTER_CYC - 1);

  always_ff @(posedge clk) begin
    if (sys_rst || tick) begin
      qcnt_ff <= '0;
    end else begin
      qcnt_ff <= qcnt_ff + 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // bus sequencer: each step spans four quarters
  // --------------------------------------------------------------------------
  etws_mst_state_t state_ff;
  logic [1:0]      qph_ff;
  logic [3:0]      bidx_ff;
  logic [8:0]      tx_ff;
  logic [8:0]      rx_ff;
  logic            scl_ff;
  logic            oe_ff;
  logic            owned_ff;
  logic            accept;

  // a fresh Start waits for a free bus; data line high while we hold clock high
  assign cmd_ready = state_ff == MS_IDLE && (cmd_kind != CMD_START || owned_ff || sda_s_ff);
  assign accept    = cmd_valid && cmd_ready;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= MS_IDLE;
      qph_ff   <= 2'h0;
      bidx_ff  <= 4'h0;
      tx_ff    <= 9'h1FF;
      rx_ff    <= 9'h1FF;
      scl_ff   <= 1'b1;
      oe_ff    <= 1'b0;
      owned_ff <= 1'b0;
    end else if (accept) begin
      qph_ff  <= 2'h0;
      bidx_ff <= 4'h0;
      unique case (cmd_kind)
        CMD_START: state_ff <= MS_START;
        CMD_STOP:  state_ff <= MS_STOP;
        CMD_WRITE: begin
          state_ff <= MS_BIT;
          tx_ff    <= {cmd_data, 1'b1};
        end
        CMD_READ: begin
          state_ff <= MS_BIT;
          tx_ff    <= {8'hFF, cmd_nack};
        end
      endcase
    end else if (tick && state_ff != MS_IDLE) begin
      qph_ff <= qph_ff + 2'h1;
      unique case (state_ff)
        MS_START: begin
          unique case (qph_ff)
            2'h0: oe_ff  <= 1'b0;
            2'h1: scl_ff <= 1'b1;
            2'h2: oe_ff  <= 1'b1;
            2'h3: begin
              scl_ff   <= 1'b0;
              owned_ff <= 1'b1;
              state_ff <= MS_IDLE;
            end
          endcase
        end
        MS_BIT: begin
          unique case (qph_ff)
            2'h0: oe_ff  <= ~tx_ff[8];
            2'h1: scl_ff <= 1'b1;
            2'h2: rx_ff  <= {rx_ff[7:0], sda_s_ff};
            2'h3: begin
              scl_ff  <= 1'b0;
              tx_ff   <= {tx_ff[7:0], 1'b1};
              bidx_ff <= bidx_ff + 4'h1;
              if (bidx_ff == 4'h8) begin
                state_ff <= MS_IDLE;
              end
            end
          endcase
        end
        MS_STOP: begin
          unique case (qph_ff)
            2'h0: oe_ff  <= 1'b1;
            2'h1: scl_ff <= 1'b1;
            2'h2: oe_ff  <= 1'b0;
            2'h3: begin
              owned_ff <= 1'b0;
              state_ff <= MS_IDLE;
            end
          endcase
        end
        default: state_ff <= MS_IDLE;
      endcase
    end
  end

  assign bus.scl      = scl_ff;
  assign bus.m_sda_oe = oe_ff;

  // --------------------------------------------------------------------------
  // byte response
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rsp_valid <= 1'b0;
      rsp_data  <= 8'h00;
      rsp_ack   <= 1'b0;
    end else begin
      rsp_valid <= tick && state_ff == MS_BIT && qph_ff == 2'h3 && bidx_ff == 4'h8;
      rsp_data  <= rx_ff[8:1];
      rsp_ack   <= ~rx_ff[0];
    end
  end
endmodule // etws_master
`default_nettype wire

// ### verilog/etws_pkg.sv
// types shared by both ends of the two-wire link
`default_nettype none
package etws_pkg;
  typedef logic [7:0] etws_byte_t;
  typedef logic [9:0] etws_addr_t;

  typedef enum logic [2:0] {
    DS_IDLE   = 3'h0,
    DS_CTRL   = 3'h1,
    DS_ADDR   = 3'h3,
    DS_WDATA  = 3'h2,
    DS_RDATA  = 3'h6,
    DS_IGNORE = 3'h4
  } etws_dev_state_t;

  typedef enum logic [1:0] {
    MS_IDLE  = 2'h0,
    MS_START = 2'h1,
    MS_BIT   = 2'h3,
    MS_STOP  = 2'h2
  } etws_mst_state_t;

  typedef enum logic [1:0] {
    CMD_START = 2'h0,
    CMD_WRITE = 2'h1,
    CMD_READ  = 2'h2,
    CMD_STOP  = 2'h3
  } etws_cmd_t;
endpackage
`default_nettype wire
